//--- inc/fifo_blk_pkg.sv
// Purpose: Shared constants for the reader byte buffer
// Assumes: Register addresses are five bits, data is one byte
// Notes:   Status address and length split are local choices

package fifo_blk_pkg;

   // ----------------------------------------------------------------
   // Buffer geometry
   // ----------------------------------------------------------------
   localparam int unsigned BUF_DEPTH = 24;
   localparam int unsigned PTR_W = 5;
   localparam int unsigned CNT_W = 12;
   localparam int unsigned STAGE_DEPTH = 4;
   localparam logic [4:0] BUF_LAST = 5'h17;
   localparam logic [4:0] BUF_FULL = 5'h18;

   // ----------------------------------------------------------------
   // Register addresses and command codes
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_TXLEN_HI = 5'h1D;
   localparam logic [4:0] ADDR_TXLEN_LO = 5'h1E;
   localparam logic [4:0] ADDR_FIFO = 5'h1F;
   localparam logic [7:0] CMD_CLEAR = 8'h0F;

   // ----------------------------------------------------------------
   // Fill thresholds
   // ----------------------------------------------------------------
   localparam logic [4:0] LEVEL_LOW = 5'h06;
   localparam logic [4:0] LEVEL_HIGH = 5'h12;

   // ----------------------------------------------------------------
   // Status register layout and reset values
   // ----------------------------------------------------------------
   localparam int unsigned ST_FOVE = 7;
   localparam int unsigned ST_FLOL = 6;
   localparam int unsigned ST_FHIL = 5;
   localparam int unsigned ST_CNT_MSB = 4;
   localparam int unsigned TXLEN_HI_W = 4;
   localparam logic [11:0] TXLEN_RST = 12'h000;
   localparam logic [7:0] RDATA_RST = 8'h00;

endpackage

//--- logic/byte_store.sv
// Purpose: Small parameterised FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Fill-side ready is registered

`timescale 1ns/10ps

module byte_store #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 4
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Fill side
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   // Drain side
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);

   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx, next_wr_idx, rd_idx, next_rd_idx;
   logic [CW-1:0] count, next_count;
   logic in_ready, next_in_ready;
   logic push, pop;

   // Index advance with wrap at depth
   function automatic logic [AW-1:0] step(input logic [AW-1:0] idx);
      step = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
   endfunction

   // Next index, count and ready
   always_comb
   begin
      push = i_in_valid & in_ready;
      pop = (count != '0) & i_out_ready;
      next_wr_idx = push ? step(wr_idx) : wr_idx;
      next_rd_idx = pop ? step(rd_idx) : rd_idx;
      next_count = count + CW'(push) - CW'(pop);
      next_in_ready = (next_count != CW'(DEPTH));
   end

   // State registers
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end
      else if (i_ce)
      begin
         wr_idx <= next_wr_idx;
         rd_idx <= next_rd_idx;
         count <= next_count;
         in_ready <= next_in_ready;
      end
   end

   // Storage write
   always_ff @(posedge i_clk)
   begin
      if (i_ce && push)
      begin
         mem[wr_idx] <= i_in_data;
      end
   end

   assign o_in_ready = in_ready;
   assign o_out_valid = (count != '0);
   assign o_out_data = mem[rd_idx];

endmodule

//--- logic/reader_tx_rx_byte_fifo.sv
// Purpose: 24-byte circular buffer between host registers and framing
// Assumes: Register strobes and framing signals share i_clk
// Notes:   Received bytes pass a 4-entry stage before the buffer

`timescale 1ns/10ps

module reader_tx_rx_byte_fifo #(
   parameter int unsigned STAGE_DEPTH = fifo_blk_pkg::STAGE_DEPTH
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Register access
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [4:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // Commands
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   // Direction
   input wire logic i_tx_active,
   // Receive framing
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_data,
   output logic o_rx_ready,
   // Transmit framing
   output logic o_tx_valid,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   input wire logic i_tx_ready,
   // Level requests
   output logic o_irq_low,
   output logic o_irq_high
);

   localparam int unsigned CW = fifo_blk_pkg::CNT_W;
   localparam int unsigned PW = fifo_blk_pkg::PTR_W;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] buf_mem [fifo_blk_pkg::BUF_DEPTH];
   logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PW-1:0] fill, next_fill;
   logic [CW-1:0] in_cnt, next_in_cnt, out_cnt, next_out_cnt;
   logic [CW-1:0] tx_len, next_tx_len;
   logic fove, next_fove, flol, next_flol, fhil, next_fhil;
   logic tx_valid, next_tx_valid, tx_last, next_tx_last;
   logic [7:0] tx_data, next_tx_data, rdata, next_rdata;
   logic irq_low, next_irq_low, irq_high, next_irq_high;
   logic clr, host_wr_fifo, host_rd_fifo, full, empty;
   logic host_push, host_pop, rx_push, tx_pop, push, pop, ovf_evt;
   logic [7:0] wr_data;
   logic stage_valid, stage_ready;
   logic [7:0] stage_data;

   // Pointer advance with wrap at last location
   function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
      ptr_step = (p == fifo_blk_pkg::BUF_LAST) ? '0 : p + 1'b1;
   endfunction

   // ----------------------------------------------------------------
   // Receive stage
   // ----------------------------------------------------------------
   byte_store #(
      .WIDTH(8),
      .DEPTH(STAGE_DEPTH)
   ) u_rx_stage (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_in_valid(i_rx_valid),
      .i_in_data(i_rx_data),
      .o_in_ready(o_rx_ready),
      .o_out_valid(stage_valid),
      .o_out_data(stage_data),
      .i_out_ready(stage_ready)
   );

   // ----------------------------------------------------------------
   // Access decode and transfer arbitration
   // ----------------------------------------------------------------
   always_comb
   begin
      clr = i_cmd_valid && (i_cmd_code == fifo_blk_pkg::CMD_CLEAR);
      host_wr_fifo = i_reg_wr && (i_reg_addr == fifo_blk_pkg::ADDR_FIFO);
      host_rd_fifo = i_reg_rd && (i_reg_addr == fifo_blk_pkg::ADDR_FIFO);
      full = (fill == fifo_blk_pkg::BUF_FULL);
      empty = (fill == '0);
      host_push = host_wr_fifo && !full && !clr;
      ovf_evt = host_wr_fifo && full;
      host_pop = host_rd_fifo && !empty && !clr;
      rx_push = stage_valid && !full && !host_wr_fifo && !clr;
      stage_ready = rx_push;
      tx_pop = i_tx_active && !empty && !host_rd_fifo && !clr
               && (out_cnt < tx_len) // host reads can carry the counter past length
               && (!tx_valid || i_tx_ready);
      push = host_push || rx_push;
      pop = host_pop || tx_pop;
      wr_data = host_wr_fifo ? i_reg_wdata : stage_data;
   end

   // ----------------------------------------------------------------
   // Pointers, fill and counters
   // ----------------------------------------------------------------
   always_comb
   begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_in_cnt = in_cnt;
      next_out_cnt = out_cnt;
      next_fill = fill;
      if (clr)
      begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_in_cnt = '0;
         next_out_cnt = '0;
         next_fill = '0;
      end
      else
      begin
         if (push)
         begin
            next_wr_ptr = ptr_step(wr_ptr);
            next_in_cnt = in_cnt + 1'b1;
         end
         if (pop)
         begin
            next_rd_ptr = ptr_step(rd_ptr);
            next_out_cnt = out_cnt + 1'b1;
         end
         next_fill = fill + PW'(push) - PW'(pop);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         in_cnt <= '0;
         out_cnt <= '0;
         fill <= '0;
      end
      else if (i_ce)
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         in_cnt <= next_in_cnt;
         out_cnt <= next_out_cnt;
         fill <= next_fill;
      end
   end

   // Byte storage, locations 0..23
   always_ff @(posedge i_clk)
   begin
      if (i_ce && push)
      begin
         buf_mem[wr_ptr] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Registers, flags, transmit handoff and level requests
   // ----------------------------------------------------------------
   always_comb
   begin
      next_tx_len = tx_len;
      if (i_reg_wr && (i_reg_addr == fifo_blk_pkg::ADDR_TXLEN_HI))
      begin
         next_tx_len[CW-1:8] = i_reg_wdata[fifo_blk_pkg::TXLEN_HI_W-1:0];
      end
      if (i_reg_wr && (i_reg_addr == fifo_blk_pkg::ADDR_TXLEN_LO))
      begin
         next_tx_len[7:0] = i_reg_wdata;
      end
      // Sticky flags, a new overflow wins over the clear for fove only
      next_fove = (fove && !clr) || ovf_evt;
      // A clear empties the buffer without counting as a low-level event
      next_flol = (flol && !clr) || (i_tx_active && !clr && (fill >= fifo_blk_pkg::LEVEL_LOW)
                  && (next_fill < fifo_blk_pkg::LEVEL_LOW));
      next_fhil = (fhil && !clr) || (!i_tx_active && (fill <= fifo_blk_pkg::LEVEL_HIGH)
                  && (next_fill > fifo_blk_pkg::LEVEL_HIGH));
      next_irq_low = (next_fill < fifo_blk_pkg::LEVEL_LOW);
      next_irq_high = (next_fill > fifo_blk_pkg::LEVEL_HIGH);
      // Transmit handoff register
      next_tx_valid = tx_valid && !i_tx_ready;
      next_tx_data = tx_data;
      next_tx_last = 1'b0;
      if (clr)
      begin
         next_tx_valid = 1'b0;
      end
      else if (tx_pop)
      begin
         next_tx_valid = 1'b1;
         next_tx_data = buf_mem[rd_ptr];
         next_tx_last = ((out_cnt + 1'b1) == tx_len);
      end
      // Read data
      next_rdata = rdata;
      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            fifo_blk_pkg::ADDR_FIFO: next_rdata = empty ? fifo_blk_pkg::RDATA_RST : buf_mem[rd_ptr];
            fifo_blk_pkg::ADDR_TXLEN_HI: next_rdata = {4'h0, tx_len[CW-1:8]};
            fifo_blk_pkg::ADDR_TXLEN_LO: next_rdata = tx_len[7:0];
            fifo_blk_pkg::ADDR_STATUS: next_rdata = {fove, flol, fhil, fill};
            default: next_rdata = fifo_blk_pkg::RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         tx_len <= fifo_blk_pkg::TXLEN_RST;
         fove <= 1'b0;
         flol <= 1'b0;
         fhil <= 1'b0;
         irq_low <= 1'b1;
         irq_high <= 1'b0;
         tx_valid <= 1'b0;
         tx_data <= fifo_blk_pkg::RDATA_RST;
         tx_last <= 1'b0;
         rdata <= fifo_blk_pkg::RDATA_RST;
      end
      else if (i_ce)
      begin
         tx_len <= next_tx_len;
         fove <= next_fove;
         flol <= next_flol;
         fhil <= next_fhil;
         irq_low <= next_irq_low;
         irq_high <= next_irq_high;
         tx_valid <= next_tx_valid;
         tx_data <= next_tx_data;
         tx_last <= next_tx_last;
         rdata <= next_rdata;
      end
   end

   // Output drive
   assign o_reg_rdata = rdata;
   assign o_tx_valid = tx_valid;
   assign o_tx_data = tx_data;
   assign o_tx_last = tx_last;
   assign o_irq_low = irq_low;
   assign o_irq_high = irq_high;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_wrap;
      (i_ce && push && (wr_ptr == fifo_blk_pkg::BUF_LAST)) |=> (wr_ptr == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

   property p_clear;
      (i_ce && clr) |=> (fill == '0) && (wr_ptr == '0) && (rd_ptr == '0) && (in_cnt == '0) && !o_tx_valid;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left state behind");

   property p_bound;
      (fill <= fifo_blk_pkg::BUF_FULL) && (wr_ptr <= fifo_blk_pkg::BUF_LAST) && (rd_ptr <= fifo_blk_pkg::BUF_LAST);
   endproperty
   a_bound: assert property (p_bound) else $error("buffer position out of range");

   property p_in_cnt;
      (i_ce && push) |=> (in_cnt == $past(in_cnt) + 1'b1);
   endproperty
   a_in_cnt: assert property (p_in_cnt) else $error("input counter missed a byte");

   property p_out_cnt;
      (i_ce && pop) |=> (out_cnt == $past(out_cnt) + 1'b1);
   endproperty
   a_out_cnt: assert property (p_out_cnt) else $error("output counter missed a byte");

   property p_cnt_diff;
      (in_cnt - out_cnt) == CW'(fill);
   endproperty
   a_cnt_diff: assert property (p_cnt_diff) else $error("counters disagree with fill");

   property p_levels;
      (o_irq_low == (fill < fifo_blk_pkg::LEVEL_LOW)) && (o_irq_high == (fill > fifo_blk_pkg::LEVEL_HIGH));
   endproperty
   a_levels: assert property (p_levels) else $error("level request wrong");

   property p_len_stop;
      (i_ce && (out_cnt == tx_len) && i_tx_ready && !clr) |=> !o_tx_valid
         ##1 ((out_cnt == $past(out_cnt)) || $past(host_pop) || $past(clr) || ($past(tx_len) != $past(tx_len, 2)));
   endproperty
   a_len_stop: assert property (p_len_stop) else $error("byte sent past length");

   property p_last;
      o_tx_last |-> o_tx_valid && (out_cnt == tx_len);
   endproperty
   a_last: assert property (p_last) else $error("last marker misplaced");

   property p_status;
      (i_ce && i_reg_rd && (i_reg_addr == fifo_blk_pkg::ADDR_STATUS)) |=> (o_reg_rdata[4:0] == $past(fill));
   endproperty
   a_status: assert property (p_status) else $error("status count wrong");

   property p_ovf;
      (i_ce && host_wr_fifo && full && !clr) |=> fove && (wr_ptr == $past(wr_ptr)) && (in_cnt == $past(in_cnt));
   endproperty
   a_ovf: assert property (p_ovf) else $error("full write not dropped");

   property p_flol;
      (i_ce && i_tx_active && (fill == fifo_blk_pkg::LEVEL_LOW) && pop && !push && !clr) |=> flol;
   endproperty
   a_flol: assert property (p_flol) else $error("low flag not set");

   property p_fhil;
      (i_ce && !i_tx_active && (fill == fifo_blk_pkg::LEVEL_HIGH + 1'b0) && push && !pop && !clr) |=> fhil;
   endproperty
   a_fhil: assert property (p_fhil) else $error("high flag not set");

   c_full: cover property (fill == fifo_blk_pkg::BUF_FULL);
   c_wrap: cover property (i_ce && push && (wr_ptr == fifo_blk_pkg::BUF_LAST));
   c_last: cover property (o_tx_last);
   c_ovf: cover property (i_ce && ovf_evt);

endmodule

//--- dv/framing_model.sv
// Purpose: Far-side framing logic: receive source, transmit sink
// Assumes: Drives at falling edge, samples at rising edge
// Notes:   Sink mode 0 stalls, 1 prompt, 2 accepts every other cycle

`timescale 1ns/10ps

module framing_model (
   // Clock
   input wire logic i_clk,
   // Receive source
   output logic o_rx_valid,
   output logic [7:0] o_rx_data,
   input wire logic i_rx_ready,
   // Transmit sink
   input wire logic i_tx_valid,
   input wire logic [7:0] i_tx_data,
   input wire logic i_tx_last,
   output logic o_tx_ready,
   input wire logic [1:0] i_mode
);
   logic [7:0] rx_q[$];
   logic [8:0] tx_seen[$];
   logic taken;
   logic last_hold;

   // Idle outputs
   initial
   begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h5A;
      o_tx_ready = 1'b0;
      taken = 1'b0;
      last_hold = 1'b0;
   end

   // Note handshakes, capture sent bytes with last flag
   // Last is a one-cycle pulse, so it is held until its byte is taken
   always @(posedge i_clk)
   begin
      taken <= o_rx_valid && i_rx_ready;
      if (i_tx_valid && o_tx_ready)
      begin
         tx_seen.push_back({i_tx_last || last_hold, i_tx_data});
         last_hold <= 1'b0;
      end
      else if (i_tx_last)
         last_hold <= 1'b1;
   end

   // Advance source; idle data keeps toggling
   always @(negedge i_clk)
   begin
      if (taken)
         void'(rx_q.pop_front());
      if (rx_q.size() > 0)
      begin
         o_rx_valid = 1'b1;
         o_rx_data = rx_q[0];
      end
      else
      begin
         o_rx_valid = 1'b0;
         o_rx_data = ~o_rx_data;
      end
      o_tx_ready = (i_mode == 2'd1) || ((i_mode == 2'd2) && !o_tx_ready);
   end
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the reader byte buffer
// Assumes: Inputs change at the falling edge
// Notes:   Status field masks hide flags a scenario does not set up

`timescale 1ns/10ps

module tb_top;
   logic i_clk, i_rst, reg_wr, reg_rd, cmd_valid, tx_active, ce;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, cmd_code, rdata, rx_data, tx_data;
   logic rx_valid, rx_ready, tx_valid, tx_last, tx_ready, irq_low, irq_high;
   logic [1:0] sink_mode;
   int fail_count, samples_checked;

   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   reader_tx_rx_byte_fifo i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(rdata), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
      .i_tx_active(tx_active), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
      .i_tx_ready(tx_ready), .o_irq_low(irq_low), .o_irq_high(irq_high));
   framing_model i_far (.i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
      .i_rx_ready(rx_ready), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
      .o_tx_ready(tx_ready), .i_mode(sink_mode));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   // Compare and count
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
      @(negedge i_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge i_clk);
      reg_wr = 1'b0;
   endtask

   // Read strobe, data taken one cycle later, masked compare
   task automatic expect_reg(input string what, input logic [4:0] a, input logic [7:0] exp,
                             input logic [7:0] mask);
      @(negedge i_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge i_clk);
      reg_rd = 1'b0;
      check(what, {8'h00, rdata & mask}, {8'h00, exp});
   endtask

   // Command strobe
   task automatic command(input logic [7:0] c);
      @(negedge i_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      @(negedge i_clk);
      cmd_valid = 1'b0;
   endtask

   // Verdict and end of run
   task automatic final_report;
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   initial
   begin
      #2_000_000;
      fail_count++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial
   begin
      i_rst = 1'b1;
      ce = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      tx_active = 1'b0;
      sink_mode = 2'd0;
      fail_count = 0;
      samples_checked = 0;
      repeat (10) @(negedge i_clk);
      i_rst = 1'b0;
      // Reset state and unmapped read
      check("irq_low", {15'h0000, irq_low}, 16'h0001);
      check("irq_high", {15'h0000, irq_high}, 16'h0000);
      expect_reg("status", fifo_blk_pkg::ADDR_STATUS, 8'h00, 8'hFF);
      expect_reg("unmapped", 5'h05, 8'h00, 8'hFF);
      // Host stream one past capacity
      for (int i = 0; i < 25; i++)
         reg_write(fifo_blk_pkg::ADDR_FIFO, 8'h40 + 8'(i));
      expect_reg("status full", fifo_blk_pkg::ADDR_STATUS, 8'h98, 8'h9F);
      check("irq_high", {15'h0000, irq_high}, 16'h0001);
      check("irq_low", {15'h0000, irq_low}, 16'h0000);
      command(8'h10);
      expect_reg("other code", fifo_blk_pkg::ADDR_STATUS, 8'h98, 8'h9F);
      for (int i = 0; i < 24; i++)
         expect_reg("fifo", fifo_blk_pkg::ADDR_FIFO, 8'h40 + 8'(i), 8'hFF);
      expect_reg("empty read", fifo_blk_pkg::ADDR_FIFO, 8'h00, 8'hFF);
      check("irq_low", {15'h0000, irq_low}, 16'h0001);
      // Positions wrap past the last location
      for (int i = 0; i < 3; i++)
         reg_write(fifo_blk_pkg::ADDR_FIFO, 8'hC0 + 8'(i));
      for (int i = 0; i < 3; i++)
         expect_reg("wrap", fifo_blk_pkg::ADDR_FIFO, 8'hC0 + 8'(i), 8'hFF);
      command(fifo_blk_pkg::CMD_CLEAR);
      expect_reg("cleared", fifo_blk_pkg::ADDR_STATUS, 8'h00, 8'hFF);
      // Receive burst overruns buffer and stage, nothing lost
      for (int i = 0; i < 30; i++)
         i_far.rx_q.push_back(8'h80 + 8'(i));
      repeat (60) @(negedge i_clk);
      check("rx_ready", {15'h0000, rx_ready}, 16'h0000);
      expect_reg("status rx", fifo_blk_pkg::ADDR_STATUS, 8'h38, 8'hBF);
      for (int i = 0; i < 30; i++)
         expect_reg("rx byte", fifo_blk_pkg::ADDR_FIFO, 8'h80 + 8'(i), 8'hFF);
      expect_reg("sticky high", fifo_blk_pkg::ADDR_STATUS, 8'h20, 8'hFF);
      // Transmit capped by length, last marked
      command(fifo_blk_pkg::CMD_CLEAR);
      reg_write(fifo_blk_pkg::ADDR_TXLEN_HI, 8'hF0);
      reg_write(fifo_blk_pkg::ADDR_TXLEN_LO, 8'h08);
      expect_reg("len hi", fifo_blk_pkg::ADDR_TXLEN_HI, 8'h00, 8'hFF);
      expect_reg("len lo", fifo_blk_pkg::ADDR_TXLEN_LO, 8'h08, 8'hFF);
      for (int i = 0; i < 10; i++)
         reg_write(fifo_blk_pkg::ADDR_FIFO, 8'h20 + 8'(i));
      @(negedge i_clk);
      tx_active = 1'b1;
      repeat (5) @(negedge i_clk);
      check("tx hold", {7'h00, tx_valid, tx_data}, 16'h0120);
      sink_mode = 2'd2;
      repeat (40) @(negedge i_clk);
      check("tx count", 16'(i_far.tx_seen.size()), 16'h0008);
      for (int i = 0; i < 8; i++)
         check("tx byte", {7'h00, i_far.tx_seen[i]}, {7'h00, i == 7, 8'h20 + 8'(i)});
      check("tx idle", {15'h0000, tx_valid}, 16'h0000);
      expect_reg("status tx", fifo_blk_pkg::ADDR_STATUS, 8'h42, 8'hFF);
      // Enable low freezes state: write and clear ignored
      ce = 1'b0;
      reg_write(fifo_blk_pkg::ADDR_FIFO, 8'hEE);
      command(fifo_blk_pkg::CMD_CLEAR);
      ce = 1'b1;
      expect_reg("frozen", fifo_blk_pkg::ADDR_STATUS, 8'h42, 8'hFF);
      // Reset in mid-run restores length, flags and levels
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_rst = 1'b0;
      check("irq_low rst", {15'h0000, irq_low}, 16'h0001);
      expect_reg("len lo rst", fifo_blk_pkg::ADDR_TXLEN_LO, 8'h00, 8'hFF);
      expect_reg("status rst", fifo_blk_pkg::ADDR_STATUS, 8'h00, 8'hFF);
      final_report();
   end
endmodule
